// ---- rtl/main_clock_source_select.sv ----
// Main clock source configuration registers and reference selection.
`timescale 1ns/1ps
module main_clock_source_select
    import clk_src_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic NRST,
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    input wire logic MAIN_CLK_ACTIVE,
    input wire logic REF_CLK_PIN,
    input wire logic FRAME_SYNC_IN,
    output logic [1:0] SAMPLE_RATE_SEL,
    output logic [5:0] SAMPLE_RATE_KSPS,
    output logic LOOP_REF_SEL,
    output logic LOOP_CLOSED_SEL,
    output logic MAIN_CLK_MUX_SEL,
    output logic [1:0] REF_PRESCALE,
    output logic [12:0] REF_DIVIDE_VALUE,
    output logic OSC_ENABLE,
    output logic OSC_OPEN_LOOP,
    output logic LOOP_ENABLE,
    output logic LEVEL_DETECT_OK,
    output logic DIVIDED_REF_CLK,
    output logic LOOP_REF_PULSE
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [7:0] config_r;
        logic [4:0] div_high;
        logic [7:0] div_low;
        logic [7:0] rdata;
        logic [1:0] ref_sync;
        logic ref_prev;
        logic [1:0] fs_sync;
        logic fs_prev;
        logic div_out;
        logic loop_ref;
        logic osc_en;
        logic osc_open;
        logic loop_en;
        logic level_ok;
        logic [5:0] ksps;
    } sel_state_t;

    sel_state_t st_reg;
    sel_state_t st_next;
    logic ref_edge;
    logic fs_edge;
    logic div_pulse;

    localparam int SEL_CONFIG = 0;
    localparam int SEL_DIV_HIGH = 1;
    localparam int SEL_DIV_LOW = 2;

    function automatic logic [5:0] rate_ksps(input logic [1:0] code);
        case (code)
            2'h0: rate_ksps = RATE_8_KSPS;
            2'h1: rate_ksps = RATE_16_KSPS;
            2'h2: rate_ksps = RATE_32_KSPS;
            default: rate_ksps = RATE_48_KSPS;
        endcase
    endfunction

    // ****************************************
    // Address decode
    // ****************************************
    // One decode feeds both the write and the read path, so the two cannot disagree.
    function automatic logic [2:0] reg_select(input logic [7:0] addr);
        reg_select = 3'h0;
        case (addr)
            CLOCK_SOURCE_CONFIG_ADDR: reg_select = 3'h1;
            REF_DIVIDER_HIGH_ADDR: reg_select = 3'h2;
            REF_DIVIDER_LOW_ADDR: reg_select = 3'h4;
            default: reg_select = 3'h0;
        endcase
    endfunction

    // ****************************************
    // Synchronised pin edges
    // ****************************************
    // Edges are taken only from the second synchroniser stage.
    // A reference pin already high at reset release shows one extra edge afterwards.
    assign ref_edge = st_reg.ref_sync[1] & ~st_reg.ref_prev;
    assign fs_edge = st_reg.fs_sync[1] & ~st_reg.fs_prev;

    // ****************************************
    // Reference divider
    // ****************************************
    ref_clk_divider #(
        .DIV_WIDTH(REF_DIVIDE_WIDTH)
    ) u_divider (
        .clk(CLK_SYS),
        .nrst(NRST),
        .ref_edge(ref_edge),
        .prescale_code(st_reg.config_r[PRESCALE_MSB:PRESCALE_LSB]),
        .divide_value({st_reg.div_high, st_reg.div_low}),
        .div_pulse(div_pulse)
    );

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic loop_closed;
        logic mux_vco;
        logic [2:0] sel;
        loop_closed = 1'b0;
        mux_vco = 1'b0;
        sel = reg_select(REG_ADDR);
        st_next = st_reg;
        st_next.ref_sync = {st_reg.ref_sync[0], REF_CLK_PIN};
        st_next.ref_prev = st_reg.ref_sync[1];
        st_next.fs_sync = {st_reg.fs_sync[0], FRAME_SYNC_IN};
        st_next.fs_prev = st_reg.fs_sync[1];

        // ****************************************
        // Register write
        // ****************************************
        // Each byte takes effect on its own write edge; there is no staging latch.
        if (REG_WR) begin
            // Source changes under a running main clock could glitch it.
            if (sel[SEL_CONFIG] && !MAIN_CLK_ACTIVE) begin
                st_next.config_r = REG_WDATA & CONFIG_WRITE_MASK;
            end
            if (sel[SEL_DIV_HIGH]) begin
                st_next.div_high = REG_WDATA[4:0];
            end
            if (sel[SEL_DIV_LOW]) begin
                st_next.div_low = REG_WDATA;
            end
        end

        // ****************************************
        // Register read
        // ****************************************
        // Unmapped addresses read a fixed value, so a stray poll never sees a stale byte.
        st_next.rdata = UNMAPPED_READ_VALUE;
        if (sel[SEL_CONFIG]) begin
            st_next.rdata = st_reg.config_r;
        end
        if (sel[SEL_DIV_HIGH]) begin
            st_next.rdata = {3'h0, st_reg.div_high};
        end
        if (sel[SEL_DIV_LOW]) begin
            st_next.rdata = st_reg.div_low;
        end

        // ****************************************
        // Decoded clock controls
        // ****************************************
        loop_closed = st_next.config_r[LOOP_CLOSED_BIT];
        mux_vco = st_next.config_r[MAIN_CLK_MUX_BIT];
        st_next.ksps = rate_ksps(st_next.config_r[SAMPLE_RATE_MSB:SAMPLE_RATE_LSB]);
        // The VCO runs whenever it clocks the device or the loop is closed.
        st_next.osc_en = mux_vco | loop_closed;
        st_next.osc_open = ~loop_closed;
        st_next.loop_en = loop_closed;
        // Open-loop VCO as main clock needs no external reference at all.
        st_next.level_ok = mux_vco & ~loop_closed;

        // ****************************************
        // Loop reference
        // ****************************************
        st_next.div_out = div_pulse;
        // Frame sync is only a valid reference with the audio port in slave mode.
        if (st_reg.config_r[LOOP_REF_BIT]) begin
            st_next.loop_ref = fs_edge;
        end else begin
            st_next.loop_ref = div_pulse;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            st_reg <= '0;
            st_reg.config_r <= CLOCK_SOURCE_CONFIG_RESET;
            st_reg.div_high <= REF_DIVIDER_HIGH_RESET[4:0];
            st_reg.div_low <= REF_DIVIDER_LOW_RESET;
            st_reg.osc_open <= 1'b1;
            // The rate output must match the reset rate code from the first edge on.
            st_reg.ksps <= rate_ksps(CLOCK_SOURCE_CONFIG_RESET[SAMPLE_RATE_MSB:SAMPLE_RATE_LSB]);
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign REG_RDATA = st_reg.rdata;
    assign SAMPLE_RATE_SEL = st_reg.config_r[SAMPLE_RATE_MSB:SAMPLE_RATE_LSB];
    assign SAMPLE_RATE_KSPS = st_reg.ksps;
    assign LOOP_REF_SEL = st_reg.config_r[LOOP_REF_BIT];
    assign LOOP_CLOSED_SEL = st_reg.config_r[LOOP_CLOSED_BIT];
    assign MAIN_CLK_MUX_SEL = st_reg.config_r[MAIN_CLK_MUX_BIT];
    assign REF_PRESCALE = st_reg.config_r[PRESCALE_MSB:PRESCALE_LSB];
    assign REF_DIVIDE_VALUE = {st_reg.div_high, st_reg.div_low};
    assign OSC_ENABLE = st_reg.osc_en;
    assign OSC_OPEN_LOOP = st_reg.osc_open;
    assign LOOP_ENABLE = st_reg.loop_en;
    assign LEVEL_DETECT_OK = st_reg.level_ok;
    assign DIVIDED_REF_CLK = st_reg.div_out;
    assign LOOP_REF_PULSE = st_reg.loop_ref;

endmodule

// ---- rtl/clk_src_pkg.sv ----
// Shared constants for the main clock source selection block.
package clk_src_pkg;

    // ****************************************
    // Register offsets and reset values
    // ****************************************
    localparam logic [7:0] CLOCK_SOURCE_CONFIG_ADDR = 8'h03;
    localparam logic [7:0] REF_DIVIDER_HIGH_ADDR = 8'h04;
    localparam logic [7:0] REF_DIVIDER_LOW_ADDR = 8'h05;
    localparam logic [7:0] CLOCK_SOURCE_CONFIG_RESET = 8'h00;
    localparam logic [7:0] REF_DIVIDER_HIGH_RESET = 8'h00;
    localparam logic [7:0] REF_DIVIDER_LOW_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int SAMPLE_RATE_LSB = 5;
    localparam int SAMPLE_RATE_MSB = 6;
    localparam int LOOP_REF_BIT = 4;
    localparam int LOOP_CLOSED_BIT = 3;
    localparam int MAIN_CLK_MUX_BIT = 2;
    localparam int PRESCALE_LSB = 0;
    localparam int PRESCALE_MSB = 1;
    localparam logic [7:0] CONFIG_WRITE_MASK = 8'h7F;
    localparam logic [7:0] DIV_HIGH_WRITE_MASK = 8'h1F;
    localparam int REF_DIVIDE_WIDTH = 13;

    // ****************************************
    // Sample rates and prescaler terminal counts
    // ****************************************
    localparam logic [5:0] RATE_8_KSPS = 6'h08;
    localparam logic [5:0] RATE_16_KSPS = 6'h10;
    localparam logic [5:0] RATE_32_KSPS = 6'h20;
    localparam logic [5:0] RATE_48_KSPS = 6'h30;
    localparam logic [1:0] PRESCALE_LAST_DIV1 = 2'h0;
    localparam logic [1:0] PRESCALE_LAST_DIV2 = 2'h1;
    localparam logic [1:0] PRESCALE_LAST_DIV4 = 2'h3;

    // Nominal frequency of the low power oscillator, in kHz.
    localparam int LOW_POWER_OSC_KHZ = 24576;

endpackage

// ---- rtl/ref_clk_divider.sv ----
// Reference pre-divider followed by the 13-bit reference divider.
`timescale 1ns/1ps
module ref_clk_divider
    import clk_src_pkg::*;
#(
    parameter int DIV_WIDTH = REF_DIVIDE_WIDTH
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ref_edge,
    input wire logic [1:0] prescale_code,
    input wire logic [DIV_WIDTH-1:0] divide_value,
    output logic div_pulse
);

    typedef struct packed {
        logic [1:0] pre_cnt;
        logic [DIV_WIDTH-1:0] div_cnt;
        logic pulse;
    } div_state_t;

    div_state_t st_reg;
    div_state_t st_next;
    logic [1:0] pre_last;
    logic [DIV_WIDTH-1:0] div_last;

    always_comb begin
        case (prescale_code)
            2'h0: pre_last = PRESCALE_LAST_DIV1;
            2'h1: pre_last = PRESCALE_LAST_DIV2;
            default: pre_last = PRESCALE_LAST_DIV4;
        endcase
    end

    // A zero value wraps to all ones, giving a ratio of 8192.
    assign div_last = divide_value - {{(DIV_WIDTH-1){1'b0}}, 1'b1};

    always_comb begin
        st_next = st_reg;
        st_next.pulse = 1'b0;
        if (ref_edge) begin
            // A compare by >= lets a shortened ratio restart cleanly instead of wrapping.
            if (st_reg.pre_cnt >= pre_last) begin
                st_next.pre_cnt = 2'h0;
                if (st_reg.div_cnt >= div_last) begin
                    st_next.div_cnt = '0;
                    st_next.pulse = 1'b1;
                end else begin
                    st_next.div_cnt = st_reg.div_cnt + {{(DIV_WIDTH-1){1'b0}}, 1'b1};
                end
            end else begin
                st_next.pre_cnt = st_reg.pre_cnt + 2'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign div_pulse = st_reg.pulse;

endmodule

// ---- tb/main_clock_source_select_asserts.sv ----
// Concurrent checks on the ports of the main clock source selection block.
`timescale 1ns/1ps
module main_clock_source_select_asserts (
    input wire logic CLK_SYS,
    input wire logic NRST,
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [7:0] REG_WDATA,
    input wire logic MAIN_CLK_ACTIVE,
    input wire logic [1:0] SAMPLE_RATE_SEL,
    input wire logic [5:0] SAMPLE_RATE_KSPS,
    input wire logic LOOP_REF_SEL,
    input wire logic LOOP_CLOSED_SEL,
    input wire logic MAIN_CLK_MUX_SEL,
    input wire logic [1:0] REF_PRESCALE,
    input wire logic [12:0] REF_DIVIDE_VALUE,
    input wire logic OSC_ENABLE,
    input wire logic OSC_OPEN_LOOP,
    input wire logic LOOP_ENABLE,
    input wire logic LEVEL_DETECT_OK,
    input wire logic DIVIDED_REF_CLK,
    input wire logic LOOP_REF_PULSE
);
    // ****************************************
    // Checks
    // ****************************************
    // Decoded outputs are only judged once the select bits have settled for a cycle.
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);
    AST_OPEN_LOOP: assert property ($stable(LOOP_CLOSED_SEL) && !LOOP_CLOSED_SEL
        |-> OSC_OPEN_LOOP && !LOOP_ENABLE) else $error("open loop state wrong");
    AST_CLOSED_LOOP: assert property ($stable(LOOP_CLOSED_SEL) && LOOP_CLOSED_SEL
        |-> !OSC_OPEN_LOOP && LOOP_ENABLE) else $error("closed loop state wrong");
    AST_LEVEL_DETECT: assert property ($stable({MAIN_CLK_MUX_SEL, LOOP_CLOSED_SEL})
        |-> LEVEL_DETECT_OK == (MAIN_CLK_MUX_SEL && !LOOP_CLOSED_SEL)) else $error("level");
    AST_OSC_ENABLE: assert property ($stable({MAIN_CLK_MUX_SEL, LOOP_CLOSED_SEL})
        |-> OSC_ENABLE == (MAIN_CLK_MUX_SEL || LOOP_CLOSED_SEL)) else $error("osc enable");
    AST_RATE: assert property ($stable(SAMPLE_RATE_SEL) |-> SAMPLE_RATE_KSPS ==
        (SAMPLE_RATE_SEL == 2'h3 ? 6'h30 : 6'h08 << SAMPLE_RATE_SEL)) else $error("rate");
    AST_LOCKED_CFG: assert property (MAIN_CLK_ACTIVE && REG_WR && REG_ADDR == 8'h03
        |=> $stable({SAMPLE_RATE_SEL, LOOP_REF_SEL, LOOP_CLOSED_SEL, MAIN_CLK_MUX_SEL,
        REF_PRESCALE})) else $error("config changed while clock runs");
    AST_CFG_WRITE: assert property (!MAIN_CLK_ACTIVE && REG_WR && REG_ADDR == 8'h03
        |=> {LOOP_REF_SEL, REF_PRESCALE} == $past({REG_WDATA[4], REG_WDATA[1:0]}))
        else $error("config write lost");
    AST_DIV_LOW: assert property (REG_WR && REG_ADDR == 8'h05
        |=> REF_DIVIDE_VALUE[7:0] == $past(REG_WDATA)) else $error("low byte");
    AST_DIV_HIGH: assert property (REG_WR && REG_ADDR == 8'h04
        |=> REF_DIVIDE_VALUE[12:8] == $past(REG_WDATA[4:0])) else $error("high byte");
    AST_REF_PATH: assert property (!LOOP_REF_SEL && $stable(LOOP_REF_SEL)
        |-> LOOP_REF_PULSE == DIVIDED_REF_CLK) else $error("reference path");
    AST_PULSE_ONE: assert property (DIVIDED_REF_CLK |=> !DIVIDED_REF_CLK)
        else $error("divided pulse too long");
endmodule
bind main_clock_source_select main_clock_source_select_asserts i_main_clock_source_select_asserts (.*);

// ---- tb/main_clock_source_select_tb.sv ----
// Self-checking bench for the main clock source selection block.
`timescale 1ns/1ps
module main_clock_source_select_tb;
    import clk_src_pkg::*;
    logic CLK_SYS = 0, NRST = 0, REG_WR = 0, MAIN_CLK_ACTIVE = 0, REF_CLK_PIN = 0;
    logic FRAME_SYNC_IN = 0, ref_run = 0, rdv = 0, rdv_d = 0;
    logic [7:0] REG_ADDR = 0, REG_WDATA = 0, REG_RDATA, cfg = 0, r;
    logic [1:0] SAMPLE_RATE_SEL, REF_PRESCALE, rc = 0;
    logic [5:0] SAMPLE_RATE_KSPS;
    logic [12:0] REF_DIVIDE_VALUE;
    logic LOOP_REF_SEL, LOOP_CLOSED_SEL, MAIN_CLK_MUX_SEL, OSC_ENABLE, OSC_OPEN_LOOP;
    logic LOOP_ENABLE, LEVEL_DETECT_OK, DIVIDED_REF_CLK, LOOP_REF_PULSE;
    logic [24:0] q[$];
    int mismatches = 0, comparisons = 0, cyc = 0, lrp = 0, n0;
    int tp[5] = '{0, 1, 2, 3, 0}, td[5] = '{1, 3, 2, 5, 0}, tr[5] = '{1, 6, 8, 20, 8192};
    main_clock_source_select i_main_clock_source_select (.*);
    always #25 CLK_SYS = ~CLK_SYS;
    // ****************************************
    // Helpers
    // ****************************************
    // Reference toggles every two cycles so the synchroniser never misses a phase.
    always @(posedge CLK_SYS) begin
        rc <= rc + 2'h1;
        rdv_d <= rdv;
        if (ref_run) REF_CLK_PIN <= rc[1];
        if (LOOP_REF_PULSE === 1'b1) lrp <= lrp + 1;
        cyc <= cyc + 1;
        // The slowest divider case needs two full periods of 4 * 8192 cycles.
        if (cyc == 80000) begin
            mismatches++;
            final_report();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [16:0] outs(input logic [7:0] c);
        return {c[6:5] == 2'h3 ? 6'h30 : 6'h08 << c[6:5], c[4:2], c[1:0], c[2] | c[3],
            ~c[3], c[3], c[2] & ~c[3], c[6:5]};
    endfunction
    // Read data is registered, so the note is compared half a cycle after it lands.
    always @(negedge CLK_SYS) if (rdv_d) chk({REG_RDATA, SAMPLE_RATE_KSPS, LOOP_REF_SEL,
        LOOP_CLOSED_SEL, MAIN_CLK_MUX_SEL, REF_PRESCALE, OSC_ENABLE, OSC_OPEN_LOOP,
        LOOP_ENABLE, LEVEL_DETECT_OK, SAMPLE_RATE_SEL}, q.pop_front());
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK_SYS);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1;
        @(posedge CLK_SYS);
        REG_WR <= 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge CLK_SYS);
        REG_ADDR <= a;
        rdv <= 1;
        q.push_back({e, outs(cfg)});
        @(posedge CLK_SYS);
        rdv <= 0;
    endtask
    task automatic final_report();
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        r = 8'($urandom(32'h0b393a22));
        repeat (16) @(posedge CLK_SYS);
        NRST <= 1;
        foreach (tp[i]) rd(8'(8'h03 + i), 8'h00);
        $display("reset test done");
        cfg = 8'h04;
        wr(8'h03, cfg);
        MAIN_CLK_ACTIVE <= 1;
        rd(8'h03, cfg);
        MAIN_CLK_ACTIVE <= 0;
        $display("start test done");
        for (int i = 0; i < 8; i++) begin
            r = 8'($urandom);
            cfg = {r[7], i[1:0], r[4:0]};
            wr(8'h03, cfg);
            cfg[7] = 0;
            rd(8'h03, cfg);
            wr(8'h04, r);
            rd(8'h04, {3'h0, r[4:0]});
        end
        $display("config test done");
        wr(8'h05, 8'hA5);
        MAIN_CLK_ACTIVE <= 1;
        wr(8'h03, ~cfg);
        rd(8'h03, cfg);
        rd(8'h05, 8'hA5);
        wr(8'h07, 8'hFF);
        rd(8'h07, 8'h00);
        MAIN_CLK_ACTIVE <= 0;
        $display("lock test done");
        ref_run <= 1;
        foreach (tp[i]) begin
            cfg = 8'(tp[i]);
            wr(8'h03, cfg);
            wr(8'h04, 8'(td[i] >> 8));
            wr(8'h05, 8'(td[i]));
            @(posedge CLK_SYS iff DIVIDED_REF_CLK === 1'b1);
            n0 = cyc;
            @(posedge CLK_SYS iff DIVIDED_REF_CLK === 1'b1);
            chk(cyc - n0, 4 * tr[i]);
        end
        $display("divider test done");
        ref_run <= 0;
        cfg = 8'h10;
        wr(8'h03, cfg);
        repeat (8) @(posedge CLK_SYS);
        n0 = lrp;
        repeat (3) begin
            FRAME_SYNC_IN <= 1;
            repeat (4) @(posedge CLK_SYS);
            FRAME_SYNC_IN <= 0;
            repeat (4) @(posedge CLK_SYS);
        end
        chk(lrp - n0, 3);
        $display("frame sync test done");
        final_report();
    end
endmodule
